/* design/tgsm_in_filter.sv */
// Channel one input stage: two-flop resynchroniser and digital filter.
// Assumes the pin is asynchronous to clk_i; filter code is static-ish.
`timescale 1ns/10ps
`default_nettype none
module tgsm_in_filter (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic pin_i,
    input wire logic [3:0] filter_i,
    output logic level_o
);
    logic sync1;
    logic sync2;
    logic [3:0] run_len;
    logic [3:0] next_run_len;
    logic next_level;

    // Resynchroniser; the first flop feeds only the second
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
        end else begin
            sync1 <= pin_i;
            sync2 <= sync1;
        end
    end

    // Level accepted after filter_i equal samples; zero code passes through
    always_comb begin
        next_level = level_o;
        next_run_len = 4'h0;
        if (filter_i == tgsm_pkg::FLT_NONE) begin
            next_level = sync2;
        end else if (sync2 != level_o) begin
            if (run_len + 4'h1 >= filter_i) begin
                next_level = sync2;
            end else begin
                next_run_len = run_len + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            level_o <= 1'b0;
            run_len <= 4'h0;
        end else begin
            level_o <= next_level;
            run_len <= next_run_len;
        end
    end

    // Unfiltered path follows the synchroniser by one cycle
    a_filter_pass: assert property (@(posedge clk_i) disable iff (!rstn_i)
        filter_i == tgsm_pkg::FLT_NONE |=> level_o == $past(sync2))
        else $error("unfiltered input not passed through");
endmodule : tgsm_in_filter
`default_nettype wire

/* design/tgsm_pkg.sv */
// Package for the gated slave-mode timer: register map, fields, codes.
// Assumes a 32-bit APB slave with byte addresses on word boundaries.
`default_nettype none
package tgsm_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_SMODE = 8'h08;
    localparam logic [7:0] OFF_MASK = 8'h0C;
    localparam logic [7:0] OFF_FLAG = 8'h10;
    localparam logic [7:0] OFF_CMODE = 8'h18;
    localparam logic [7:0] OFF_CENA = 8'h20;
    localparam logic [7:0] OFF_COUNT = 8'h24;
    // Field positions
    localparam int CEN_POS = 0;
    localparam int SMS_POS = 0;
    localparam int TS_POS = 4;
    localparam int TRIG_POS = 6;
    localparam int CCS_POS = 0;
    localparam int PSC_POS = 2;
    localparam int FLT_POS = 4;
    localparam int POL_POS = 1;
    localparam int NPOL_POS = 3;
    // Codes
    localparam logic [2:0] SMS_GATED = 3'h5;
    localparam logic [2:0] TS_CH1_FILT = 3'h5;
    localparam logic [1:0] CCS_DIRECT = 2'h1;
    localparam logic [3:0] FLT_NONE = 4'h0;
    // Reset values
    localparam logic [2:0] SMS_RST = 3'h0;
    localparam logic [2:0] TS_RST = 3'h0;
    localparam logic [6:0] MASK_RST = 7'h00;
    // Channel one input configuration carried as one group
    typedef struct packed {
        logic [3:0] filter;
        logic [1:0] psc;
        logic [1:0] sel;
    } tgsm_ch1_cfg_t;
    localparam tgsm_ch1_cfg_t CH1_RST = '{filter: 4'h0, psc: 2'h0, sel: 2'h0};
endpackage : tgsm_pkg
`default_nettype wire

/* design/tgsm_top.sv */
// Gated slave-mode timer: APB registers, gate logic, counter, interrupt.
// Assumes APB master on clk_i; channel one pin is asynchronous.
// Behaviour
// - Gated code makes input level gate counting
// - Trigger code selects filtered channel one input
// - Counter halted while enable bit is zero
// - Counts while gate active, stops otherwise
// - Trigger flag set on start and stop
// - Gate input resynchronised, stop lags edge
// - Polarity one, complement zero inverts gate
// - Direct capture code routes pin as source
// - Filter code sets duration, zero bypasses
// - Capture prescaler does not affect gate
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module tgsm_top #(
    parameter int CNT_W = 16
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic ch1_pin_i,
    output logic [CNT_W-1:0] count_o,
    output logic counting_o,
    output logic irq_o
);
    // Count must fit in one 32-bit read word
    if (CNT_W < 1 || CNT_W > 32) begin : g_bad_width
        $error("CNT_W must be 1..32");
    end

    // Register state
    logic counter_enable_bit;
    logic [2:0] slave_mode_select;
    logic [2:0] trigger_source_select;
    tgsm_pkg::tgsm_ch1_cfg_t ch1_cfg;
    logic channel1_polarity;
    logic channel1_complement_polarity;
    logic [6:0] mask;
    logic [6:0] flags;
    logic [CNT_W-1:0] count;
    logic run;
    logic gate_q;
    // Next values
    logic next_cen;
    logic [2:0] next_sms;
    logic [2:0] next_ts;
    tgsm_pkg::tgsm_ch1_cfg_t next_ch1_cfg;
    logic next_pol;
    logic next_npol;
    logic [6:0] next_mask;
    logic [6:0] next_flags;
    logic [CNT_W-1:0] next_count;
    logic next_run;
    logic next_gate_q;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_irq;
    // Decode terms
    logic setup;
    logic wr_acc;
    logic rd_acc;
    logic mapped;
    logic filtered_channel1_input;
    logic gated;
    logic src_ok;
    logic invert;
    logic gate_act;
    logic trig_evt;

    // Pin resynchronised and filtered before any gate logic sees it
    tgsm_in_filter u_filter (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .pin_i(ch1_pin_i),
        .filter_i(ch1_cfg.filter),
        .level_o(filtered_channel1_input)
    );

    function automatic logic is_mapped(input logic [7:0] a);
        return a == tgsm_pkg::OFF_CTRL || a == tgsm_pkg::OFF_SMODE
            || a == tgsm_pkg::OFF_MASK || a == tgsm_pkg::OFF_FLAG
            || a == tgsm_pkg::OFF_CMODE || a == tgsm_pkg::OFF_CENA
            || a == tgsm_pkg::OFF_COUNT;
    endfunction : is_mapped

    // APB phase decode; no wait state, read data comes from a flop loaded in the setup cycle
    assign setup = psel_i && !penable_i;
    assign mapped = is_mapped(paddr_i);
    assign wr_acc = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
    assign rd_acc = psel_i && penable_i && pready_o && !pwrite_i && !pslverr_o;

    // Gate path; prescaler field is deliberately not used here
    assign gated = slave_mode_select == tgsm_pkg::SMS_GATED;
    assign src_ok = trigger_source_select == tgsm_pkg::TS_CH1_FILT
        && ch1_cfg.sel == tgsm_pkg::CCS_DIRECT;
    assign invert = channel1_polarity && !channel1_complement_polarity;
    assign gate_act = src_ok && (filtered_channel1_input ^ invert);
    // Gate transitions only count as start/stop while enabled
    assign trig_evt = gated && counter_enable_bit && (gate_act != gate_q);

    // Register file next values
    always_comb begin
        next_cen = counter_enable_bit;
        next_sms = slave_mode_select;
        next_ts = trigger_source_select;
        next_ch1_cfg = ch1_cfg;
        next_pol = channel1_polarity;
        next_npol = channel1_complement_polarity;
        next_mask = mask;
        next_flags = flags;
        if (wr_acc) begin
            unique case (paddr_i)
                tgsm_pkg::OFF_CTRL: next_cen = pwdata_i[tgsm_pkg::CEN_POS];
                tgsm_pkg::OFF_SMODE: begin
                    next_sms = pwdata_i[tgsm_pkg::SMS_POS +: 3];
                    next_ts = pwdata_i[tgsm_pkg::TS_POS +: 3];
                end
                tgsm_pkg::OFF_MASK: next_mask = pwdata_i[6:0];
                tgsm_pkg::OFF_CMODE: begin
                    next_ch1_cfg.sel = pwdata_i[tgsm_pkg::CCS_POS +: 2];
                    next_ch1_cfg.psc = pwdata_i[tgsm_pkg::PSC_POS +: 2];
                    next_ch1_cfg.filter = pwdata_i[tgsm_pkg::FLT_POS +: 4];
                end
                tgsm_pkg::OFF_CENA: begin
                    next_pol = pwdata_i[tgsm_pkg::POL_POS];
                    next_npol = pwdata_i[tgsm_pkg::NPOL_POS];
                end
                default: ;
            endcase
        end
        // Read clears; a same-cycle event wins over the clear
        if (rd_acc && paddr_i == tgsm_pkg::OFF_FLAG) begin
            next_flags = 7'h00;
        end
        if (trig_evt) begin
            next_flags[tgsm_pkg::TRIG_POS] = 1'b1;
        end
        next_irq = |(next_flags & next_mask);
    end

    // Counter and gate tracking
    always_comb begin
        next_gate_q = gate_act;
        // Disabled counter never increments, whatever the gate level
        if (!counter_enable_bit) begin
            next_run = 1'b0;
        end else if (gated) begin
            next_run = gate_act;
        end else begin
            next_run = 1'b1;
        end
        // Closed gate just stops increments, keeping the value
        next_count = count;
        if (wr_acc && paddr_i == tgsm_pkg::OFF_COUNT) begin
            next_count = pwdata_i[CNT_W-1:0];
        end else if (next_run) begin
            next_count = count + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // Read mux, captured in the setup cycle
    always_comb begin
        next_prdata = 32'h0000_0000;
        next_pready = setup;
        next_pslverr = setup && !mapped;
        if (setup && !pwrite_i) begin
            unique case (paddr_i)
                tgsm_pkg::OFF_CTRL: next_prdata[tgsm_pkg::CEN_POS] = counter_enable_bit;
                tgsm_pkg::OFF_SMODE: begin
                    next_prdata[tgsm_pkg::SMS_POS +: 3] = slave_mode_select;
                    next_prdata[tgsm_pkg::TS_POS +: 3] = trigger_source_select;
                end
                tgsm_pkg::OFF_MASK: next_prdata[6:0] = mask;
                tgsm_pkg::OFF_FLAG: next_prdata[6:0] = flags;
                tgsm_pkg::OFF_CMODE: begin
                    next_prdata[tgsm_pkg::CCS_POS +: 2] = ch1_cfg.sel;
                    next_prdata[tgsm_pkg::PSC_POS +: 2] = ch1_cfg.psc;
                    next_prdata[tgsm_pkg::FLT_POS +: 4] = ch1_cfg.filter;
                end
                tgsm_pkg::OFF_CENA: begin
                    next_prdata[tgsm_pkg::POL_POS] = channel1_polarity;
                    next_prdata[tgsm_pkg::NPOL_POS] = channel1_complement_polarity;
                end
                tgsm_pkg::OFF_COUNT: next_prdata[CNT_W-1:0] = count;
                default: ;
            endcase
        end
    end

    // All state registers
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            counter_enable_bit <= 1'b0;
            slave_mode_select <= tgsm_pkg::SMS_RST;
            trigger_source_select <= tgsm_pkg::TS_RST;
            ch1_cfg <= tgsm_pkg::CH1_RST;
            channel1_polarity <= 1'b0;
            channel1_complement_polarity <= 1'b0;
            mask <= tgsm_pkg::MASK_RST;
            flags <= 7'h00;
            count <= '0;
            run <= 1'b0;
            gate_q <= 1'b0;
            prdata_o <= 32'h0000_0000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            counter_enable_bit <= next_cen;
            slave_mode_select <= next_sms;
            trigger_source_select <= next_ts;
            ch1_cfg <= next_ch1_cfg;
            channel1_polarity <= next_pol;
            channel1_complement_polarity <= next_npol;
            mask <= next_mask;
            flags <= next_flags;
            count <= next_count;
            run <= next_run;
            gate_q <= next_gate_q;
            prdata_o <= next_prdata;
            pready_o <= next_pready;
            pslverr_o <= next_pslverr;
            irq_o <= next_irq;
        end
    end

    assign count_o = count;
    assign counting_o = run;

    // Checks
    a_cen_halt: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !counter_enable_bit && !(wr_acc && paddr_i == tgsm_pkg::OFF_COUNT)
        |=> $stable(count))
        else $error("count moved while disabled");

    a_run_disabled: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !counter_enable_bit |=> !counting_o)
        else $error("counting flagged while disabled");

    a_gate_count: assert property (@(posedge clk_i) disable iff (!rstn_i)
        counter_enable_bit && gated && gate_act && !wr_acc
        |=> count == CNT_W'($past(count) + 1))
        else $error("open gate did not advance count");

    a_gate_run: assert property (@(posedge clk_i) disable iff (!rstn_i)
        counter_enable_bit && gated |=> counting_o == $past(gate_act))
        else $error("counting does not follow the gate");

    a_free_run: assert property (@(posedge clk_i) disable iff (!rstn_i)
        counter_enable_bit && !gated |=> counting_o)
        else $error("non-gated mode did not count");

    a_gate_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
        gated && !gate_act && !wr_acc |=> $stable(count) && !counting_o)
        else $error("closed gate did not hold count");

    a_flag_edge: assert property (@(posedge clk_i) disable iff (!rstn_i)
        gated && counter_enable_bit && $changed(gate_act)
        |=> flags[tgsm_pkg::TRIG_POS])
        else $error("gate edge did not raise trigger flag");

    a_flag_quiet: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !trig_evt && !flags[tgsm_pkg::TRIG_POS] |=> !flags[tgsm_pkg::TRIG_POS])
        else $error("trigger flag rose without a gate edge");

    a_flag_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
        rd_acc && paddr_i == tgsm_pkg::OFF_FLAG && !trig_evt
        |=> !flags[tgsm_pkg::TRIG_POS])
        else $error("flag read did not clear trigger flag");

    a_source_sel: assert property (@(posedge clk_i) disable iff (!rstn_i)
        gated && trigger_source_select != tgsm_pkg::TS_CH1_FILT && !wr_acc
        |=> $stable(count))
        else $error("unselected source gated the counter");

    a_src_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !src_ok |-> !gate_act)
        else $error("gate active without selected source");

    a_pol_invert: assert property (@(posedge clk_i) disable iff (!rstn_i)
        src_ok && channel1_polarity && !channel1_complement_polarity
        |-> gate_act == !filtered_channel1_input)
        else $error("polarity inversion wrong");

    a_err_unmapped: assert property (@(posedge clk_i) disable iff (!rstn_i)
        setup && !mapped |=> pready_o && pslverr_o)
        else $error("unmapped access not refused");

    a_read_idle: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !pready_o |-> prdata_o == 32'h0000_0000)
        else $error("read data not zero outside access");

    a_apb_answer: assert property (@(posedge clk_i) disable iff (!rstn_i)
        setup |=> pready_o ##1 !pready_o)
        else $error("APB answer not one cycle after setup");

    a_irq_level: assert property (@(posedge clk_i) disable iff (!rstn_i)
        irq_o == |(flags & mask))
        else $error("interrupt disagrees with flags and mask");
endmodule : tgsm_top
`default_nettype wire

/* sim/tgsm_gate_src.sv */
// Far-side model: the external source that drives the channel one gate pin.
// Assumes the bench commands the wanted level; the pin follows after an edge.
`timescale 1ns/10ps
`default_nettype none
module tgsm_gate_src (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic level_i,
    output logic pin_o
);
    // Pin moves just after a clock edge, never mid-cycle, so outcomes are race-free
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_o <= 1'b0;
        end else begin
            pin_o <= level_i;
        end
    end
endmodule : tgsm_gate_src
`default_nettype wire

/* sim/timer_gated_slave_mode_bench.sv */
// Self-checking bench for the gated slave-mode timer, APB master tasks.
// Assumes the zero-wait-state APB slave and register layout of the package.
`timescale 1ns/10ps
`default_nettype none
module timer_gated_slave_mode_bench;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic gate_lvl = 1'b0;
    logic ch1_pin;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic [15:0] count_o;
    logic counting_o;
    logic irq_o;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;

    // Clock at 100 MHz
    always #5 clk_i = ~clk_i;

    tgsm_top #(.CNT_W(16)) tgsm_top_i (
        .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .ch1_pin_i(ch1_pin), .count_o(count_o), .counting_o(counting_o), .irq_o(irq_o)
    );

    tgsm_gate_src tgsm_gate_src_i (
        .clk_i(clk_i), .rstn_i(rstn_i), .level_i(gate_lvl), .pin_o(ch1_pin)
    );

    task automatic give_verdict;
        $display("Checks %0d, errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; the trailing idle cycle keeps drivers one-per-step
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                       output logic [31:0] rdat, output logic err);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= addr;
        pwdata_i <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rdat = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask : apb

    task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
        logic [31:0] d;
        logic e;
        apb(1'b1, addr, wd, d, e);
    endtask : wr

    task automatic rd(input logic [7:0] addr, output logic [31:0] d);
        logic e;
        apb(1'b0, addr, 32'h0, d, e);
    endtask : rd

    // Two reads of the count three cycles apart give the advance per window
    task automatic dcheck(input logic [15:0] exp);
        logic [31:0] a;
        logic [31:0] b;
        rd(tgsm_pkg::OFF_COUNT, a);
        rd(tgsm_pkg::OFF_COUNT, b);
        check({16'h0, b[15:0] - a[15:0]}, {16'h0, exp});
    endtask : dcheck

    task automatic pulse;
        gate_lvl <= 1'b1;
        repeat (3) @(posedge clk_i);
        gate_lvl <= 1'b0;
        repeat (20) @(posedge clk_i);
    endtask : pulse

    // Hang guard, far above the few hundred cycles the sequence needs
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 4000) begin
            n_errors++;
            give_verdict();
        end
    end

    initial begin
        logic [31:0] d;
        logic [31:0] a;
        logic e;
        logic [7:0] offs [7];
        offs = '{tgsm_pkg::OFF_CTRL, tgsm_pkg::OFF_SMODE, tgsm_pkg::OFF_MASK,
                 tgsm_pkg::OFF_FLAG, tgsm_pkg::OFF_CMODE, tgsm_pkg::OFF_CENA,
                 tgsm_pkg::OFF_COUNT};
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        // Reset values, then an unmapped word
        foreach (offs[i]) begin
            rd(offs[i], d);
            check(d, 32'h0);
        end
        apb(1'b0, 8'h04, 32'h0, d, e);
        check({31'h0, e}, 32'h1);
        // Gated setup, counter enable still off
        wr(tgsm_pkg::OFF_CMODE, 32'h01);
        wr(tgsm_pkg::OFF_SMODE, 32'h55);
        gate_lvl <= 1'b1;
        repeat (10) @(posedge clk_i);
        dcheck(16'h0);
        check({31'h0, counting_o}, 32'h0);
        // Gate opens only after enabling, so its start raises the flag
        gate_lvl <= 1'b0;
        repeat (10) @(posedge clk_i);
        wr(tgsm_pkg::OFF_CTRL, 32'h1);
        gate_lvl <= 1'b1;
        repeat (8) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0);
        wr(tgsm_pkg::OFF_MASK, 32'h40);
        check({31'h0, irq_o}, 32'h1);
        rd(tgsm_pkg::OFF_FLAG, d);
        check(d & 32'h40, 32'h40);
        check({31'h0, irq_o}, 32'h0);
        dcheck(16'h3);
        wr(tgsm_pkg::OFF_CMODE, 32'h0D);
        dcheck(16'h3);
        // Close the gate: stop lags the edge, count is held
        gate_lvl <= 1'b0;
        repeat (4) @(posedge clk_i);
        check({31'h0, counting_o}, 32'h1);
        repeat (10) @(posedge clk_i);
        check({31'h0, counting_o}, 32'h0);
        dcheck(16'h0);
        check({31'h0, irq_o}, 32'h1);
        rd(tgsm_pkg::OFF_FLAG, d);
        rd(tgsm_pkg::OFF_COUNT, a);
        check({16'h0, count_o}, a);
        gate_lvl <= 1'b1;
        repeat (10) @(posedge clk_i);
        rd(tgsm_pkg::OFF_COUNT, d);
        check({31'h0, d[15:0] > a[15:0] && d[15:0] - a[15:0] < 16'h10}, 32'h1);
        // Inverted polarity, then both polarity bits set
        wr(tgsm_pkg::OFF_CENA, 32'h02);
        gate_lvl <= 1'b0;
        repeat (10) @(posedge clk_i);
        dcheck(16'h3);
        gate_lvl <= 1'b1;
        repeat (10) @(posedge clk_i);
        dcheck(16'h0);
        wr(tgsm_pkg::OFF_CENA, 32'h0A);
        repeat (10) @(posedge clk_i);
        dcheck(16'h3);
        // Short pulse: blocked by longest filter, passed with none
        wr(tgsm_pkg::OFF_CENA, 32'h00);
        gate_lvl <= 1'b0;
        wr(tgsm_pkg::OFF_CMODE, 32'hF1);
        // Longest filter needs 15 samples before the closed level settles
        repeat (30) @(posedge clk_i);
        rd(tgsm_pkg::OFF_COUNT, a);
        pulse();
        rd(tgsm_pkg::OFF_COUNT, d);
        check(d, a);
        wr(tgsm_pkg::OFF_CMODE, 32'h01);
        pulse();
        rd(tgsm_pkg::OFF_COUNT, d);
        check({31'h0, d[15:0] != a[15:0]}, 32'h1);
        // Other source code gives no gate; non-gated mode ignores the pin
        wr(tgsm_pkg::OFF_SMODE, 32'h05);
        gate_lvl <= 1'b1;
        repeat (10) @(posedge clk_i);
        dcheck(16'h0);
        wr(tgsm_pkg::OFF_SMODE, 32'h50);
        gate_lvl <= 1'b0;
        repeat (10) @(posedge clk_i);
        dcheck(16'h3);
        give_verdict();
    end
endmodule : timer_gated_slave_mode_bench
`default_nettype wire
